/* File: hdl/front_panel_pkg.sv */
// Package with constants, register map and types of the front panel control logic
package front_panel_pkg;
    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_HZ = 125000000;     // Core clock rate
    localparam int UNLOCK_HOLD_S = 4;      // Least unlock hold time in seconds
    localparam longint UNLOCK_HOLD_CYC = longint'(UNLOCK_HOLD_S) * longint'(CLK_HZ);
    localparam int BLINK_HALF_MS = 250;    // Half period of indicator blink in ms
    localparam longint BLINK_HALF_CYC = longint'(BLINK_HALF_MS) * longint'(CLK_HZ) / 1000;
    localparam int CNT_W = 32;             // Width of long counters
    localparam int DLY_W = 16;             // Width of shutdown delay value

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;    // Control bits
    localparam logic [7:0] ADR_STATUS = 8'h04;  // Status bits, read only
    localparam logic [7:0] ADR_DELAY = 8'h08;   // Shutdown delay in ticks
    localparam logic [7:0] ADR_MENU = 8'h0C;    // Menu state, read only

    // Control field positions
    localparam int C_OC_EN = 0;       // Overcurrent shutdown enable
    localparam int C_PWR_RECALL = 1;  // Power-on behaviour is recall
    localparam int C_TRIG_LOCK = 2;   // Trigger input selects panel lock
    localparam int C_SELFTEST = 3;    // Self-test running
    localparam int C_SEQ = 4;         // Sequence mode running
    localparam int C_READY = 5;       // Device ready
    localparam int C_ITEM_TEXT = 6;   // Current menu item is a text parameter
    localparam int C_ITEM_BLINK = 7;  // Current menu item blinks as a whole
    localparam logic [7:0] CTRL_RST = 8'h20; // Ready set after reset

    // Status field positions
    localparam int S_OUT_ON = 0;
    localparam int S_OTP = 1;
    localparam int S_OC_TRIP = 2;
    localparam int S_LOCKED = 3;
    localparam int S_REMOTE = 4;
    localparam int S_LLO = 5;
    localparam int S_RES_L_LO = 8;
    localparam int S_RES_R_LO = 10;
    localparam int S_CFG_RST = 12;

    // Step resolution codes: fine, medium, coarse
    localparam logic [1:0] RES_FINE = 2'h0;
    localparam logic [1:0] RES_MED = 2'h1;
    localparam logic [1:0] RES_COARSE = 2'h2;

    localparam logic [3:0] ITEM_RST = 4'h0; // First menu item

    typedef enum logic [1:0] {MENU_IDLE, MENU_OPEN} menu_state_type;
endpackage

/* File: hdl/front_panel_control_logic.sv */
// Front panel control logic: protection latches, menu, resolution, locks, indicators
// How it works
// RULE1: Overtemperature turns output off, recall re-enables
// RULE2: Long current regulation with enable trips overcurrent
// RULE3: Overcurrent keeps output off until output-on
// RULE4: Locked lamp shows key or trigger lock only
// RULE5: Acknowledge applies parameter, displays return to readouts
// RULE6: Encoder or other key closes menu unapplied
// RULE7: Output key works; resolution key numeric only
// RULE8: Non-blinking parameter applies immediately
// RULE9: Menu reopens at last opened item
// RULE10: Resolution key cycles three lowest decimal places
// RULE11: Separate resolution for left and right display
// RULE12: Configuration reset sets resolution to fine
// RULE13: Clear key aborts adjustment, setting unchanged
// RULE14: Remote ignores keys except clear, which returns local
// RULE15: Bus local lockout disables clear key
// RULE16: Clear held plus acknowledge resets configuration
// RULE17: Clear held plus recall locks panel
// RULE18: Clear held four seconds unlocks panel
// RULE19: Trigger lock mode disables clear key
// RULE20: Ready steady, blinks in self-test or sequence
// RULE21: Address and service request lamps follow bus
// RULE22: Text parameter blinks until acknowledged, else kept
// RULE23: Hold counter on clock, restarts on release
`timescale 1ns/1ps
`default_nettype none
module front_panel_control_logic #(
    parameter longint UNLOCK_CYC = front_panel_pkg::UNLOCK_HOLD_CYC,
    parameter longint BLINK_CYC = front_panel_pkg::BLINK_HALF_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Wishbone classic slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Key pulses, one cycle each, levels for clear key
    input wire logic i_key_output,
    input wire logic i_key_function,
    input wire logic i_key_up,
    input wire logic i_key_down,
    input wire logic i_key_enter,
    input wire logic i_key_recall,
    input wire logic i_key_save,
    input wire logic i_key_select,
    input wire logic i_step_resolution_key,
    input wire logic i_key_clear_held,
    input wire logic i_key_clear_press,
    input wire logic i_enc_left,
    input wire logic i_enc_right,
    input wire logic i_res_target_right,
    // Plant and bus status
    input wire logic i_overtemp,
    input wire logic i_cur_reg,
    input wire logic i_trigger_in,
    input wire logic i_remote,
    input wire logic i_bus_llo,
    input wire logic i_bus_addressed,
    input wire logic i_bus_srq,
    input wire logic i_cmd_output_on,
    input wire logic i_cmd_output_off,
    input wire logic i_delay_tick,
    // Outputs
    output logic o_output_on,
    output logic o_overtemp_trip,
    output logic o_overcurrent_trip,
    output logic o_panel_locked_indicator,
    output logic o_ready_led,
    output logic o_remote_led,
    output logic o_addr_led,
    output logic o_srq_led,
    output logic o_go_local,
    output logic o_config_reset,
    output logic o_menu_open,
    output logic [3:0] o_menu_item,
    output logic [7:0] o_menu_param,
    output logic o_param_blink,
    output logic o_param_apply,
    output logic o_display_default,
    output logic [1:0] o_res_left,
    output logic [1:0] o_res_right
);
    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic [7:0] ctrl_ff;                 // Control register
    logic [front_panel_pkg::DLY_W-1:0] delay_ff; // Shutdown delay in ticks
    logic ack_ff;                        // Bus acknowledge
    logic [31:0] rdat_ff;                // Registered read data
    wire bus_req = i_wb_cyc && i_wb_stb && !ack_ff;
    wire bus_wr = bus_req && i_wb_we;
    wire wr_ctrl = bus_wr && (i_wb_adr == front_panel_pkg::ADR_CTRL) && i_wb_sel[0];
    wire wr_dly = bus_wr && (i_wb_adr == front_panel_pkg::ADR_DELAY);
    logic [31:0] status_word;            // Live status view
    logic [31:0] menu_word;              // Live menu view
    logic [31:0] rd_mux;                 // Selected read word

    // ****************************************************************
    // Core state
    // ****************************************************************
    logic out_ff, otp_ff, oc_ff, klock_ff, cfg_rst_ff, golocal_ff;
    logic [front_panel_pkg::DLY_W-1:0] cc_cnt_ff; // Regulation duration
    logic [front_panel_pkg::CNT_W-1:0] hold_ff;   // Clear key hold counter
    logic hold_done_ff;                  // Unlock already fired for this hold
    logic [1:0] res_l_ff, res_r_ff;
    front_panel_pkg::menu_state_type menu_ff;
    logic [3:0] item_ff;                 // Last opened item, remembered
    logic [7:0] pend_ff;                 // Pending parameter value
    logic apply_ff, dflt_ff;
    logic [front_panel_pkg::CNT_W-1:0] blink_cnt_ff;
    logic blink_ff;

    // Lock sources: key combo and trigger count for the lamp, bus lockout does not
    wire trig_lock = ctrl_ff[front_panel_pkg::C_TRIG_LOCK] && i_trigger_in;
    wire panel_locked = klock_ff || trig_lock; // see RULE4
    wire clear_ok = !i_bus_llo && !trig_lock;  // see RULE15 see RULE19
    wire keys_ok = !i_remote && !panel_locked; // see RULE14
    wire k_out = keys_ok && i_key_output;
    wire k_fn = keys_ok && i_key_function;
    wire k_up = keys_ok && (i_key_up || i_key_down);
    wire k_ent = keys_ok && i_key_enter && !i_key_clear_held;
    wire k_other = keys_ok && (i_key_save || i_key_select ||
                               (i_key_recall && !i_key_clear_held));
    wire k_enc = keys_ok && (i_enc_left || i_enc_right);
    wire item_text = ctrl_ff[front_panel_pkg::C_ITEM_TEXT];
    wire item_blink = ctrl_ff[front_panel_pkg::C_ITEM_BLINK];
    wire k_res = keys_ok && i_step_resolution_key &&
                 !(menu_ff == front_panel_pkg::MENU_OPEN && item_text); // see RULE7
    wire k_clear = clear_ok && i_key_clear_press && !klock_ff;
    wire combo_rst = clear_ok && keys_ok && i_key_clear_held && i_key_enter; // see RULE16
    wire combo_lock = clear_ok && keys_ok && i_key_clear_held && i_key_recall; // see RULE17
    wire hold_hit = (hold_ff == front_panel_pkg::CNT_W'(UNLOCK_CYC - 1));
    wire unlock = klock_ff && clear_ok && i_key_clear_held && hold_hit && !hold_done_ff;
    wire oc_en = ctrl_ff[front_panel_pkg::C_OC_EN]; // Shutdown on long regulation
    wire cc_over = oc_en && i_cur_reg && (cc_cnt_ff > delay_ff); // see RULE2
    wire menu_open = (menu_ff == front_panel_pkg::MENU_OPEN);
    // Resolution step helper: wraps after coarse
    function automatic logic [1:0] res_next(input logic [1:0] r);
        res_next = (r == front_panel_pkg::RES_COARSE) ? front_panel_pkg::RES_FINE :
                   2'(r + 2'h1);
    endfunction
    // Bus registers, one-cycle wait then ack
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            ctrl_ff <= front_panel_pkg::CTRL_RST;
            delay_ff <= '0;
            ack_ff <= 1'b0;
            rdat_ff <= '0;
        end else begin
            ack_ff <= bus_req;
            rdat_ff <= rd_mux;
            if (wr_ctrl) begin
                ctrl_ff <= i_wb_dat[7:0];
            end
            if (wr_dly && i_wb_sel[0]) begin
                delay_ff[7:0] <= i_wb_dat[7:0];
            end
            if (wr_dly && i_wb_sel[1]) begin
                delay_ff[15:8] <= i_wb_dat[15:8];
            end
        end
    end
    // Read views, unmapped offsets read zero
    assign status_word = {19'h0, cfg_rst_ff, res_r_ff, res_l_ff, 2'h0, i_bus_llo,
                          i_remote, panel_locked, oc_ff, otp_ff, out_ff};
    assign menu_word = {19'h0, menu_open, item_ff, pend_ff};
    assign rd_mux = (i_wb_adr == front_panel_pkg::ADR_CTRL) ? {24'h0, ctrl_ff} :
                    (i_wb_adr == front_panel_pkg::ADR_STATUS) ? status_word :
                    (i_wb_adr == front_panel_pkg::ADR_DELAY) ? {16'h0, delay_ff} :
                    (i_wb_adr == front_panel_pkg::ADR_MENU) ? menu_word : 32'h0;
    assign o_wb_ack = ack_ff;
    assign o_wb_dat = rdat_ff;

    // ****************************************************************
    // Protection latches and output enable
    // ****************************************************************
    // Regulation-time counter, saturating, cleared out of current regulation
    always_ff @(posedge i_core_clk) begin
        if (i_reset || !i_cur_reg || !out_ff) begin
            cc_cnt_ff <= '0;
        end else if (i_delay_tick && cc_cnt_ff != '1) begin
            cc_cnt_ff <= cc_cnt_ff + 1'b1;
        end
    end

    // Output and trips; a trip beats any on request in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            out_ff <= 1'b0;
            otp_ff <= 1'b0;
            oc_ff <= 1'b0;
        end else begin
            if (i_overtemp) begin
                otp_ff <= 1'b1;
                out_ff <= 1'b0; // see RULE1
            end else if (cc_over && out_ff) begin
                oc_ff <= 1'b1;
                out_ff <= 1'b0; // see RULE2
            end else if (i_cmd_output_on || (k_out && !out_ff)) begin
                out_ff <= 1'b1; // see RULE3
                oc_ff <= 1'b0;
                otp_ff <= 1'b0;
            end else if (otp_ff && !oc_ff && ctrl_ff[front_panel_pkg::C_PWR_RECALL]) begin
                out_ff <= 1'b1; // see RULE1
                otp_ff <= 1'b0;
            end else if (otp_ff) begin
                otp_ff <= 1'b0; // Cooled: may be turned on again
            end else if (i_cmd_output_off || k_out) begin
                out_ff <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Clear key hold, lock and reset combos
    // ****************************************************************
    // Hold counter; any release restarts it
    always_ff @(posedge i_core_clk) begin
        if (i_reset || !i_key_clear_held) begin
            hold_ff <= '0; // see RULE23
            hold_done_ff <= 1'b0;
        end else if (hold_hit) begin
            hold_done_ff <= 1'b1;
        end else begin
            hold_ff <= hold_ff + 1'b1;
        end
    end

    // Panel key lock, local return and configuration reset pulses
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            klock_ff <= 1'b0;
            golocal_ff <= 1'b0;
            cfg_rst_ff <= 1'b0;
        end else begin
            golocal_ff <= i_remote && clear_ok && i_key_clear_press; // see RULE14
            cfg_rst_ff <= combo_rst;
            if (combo_lock) begin
                klock_ff <= 1'b1; // see RULE17
            end else if (unlock) begin
                klock_ff <= 1'b0; // see RULE18
            end
        end
    end

    // ****************************************************************
    // Step resolution per display
    // ****************************************************************
    always_ff @(posedge i_core_clk) begin
        if (i_reset || cfg_rst_ff) begin
            res_l_ff <= front_panel_pkg::RES_FINE; // see RULE12
            res_r_ff <= front_panel_pkg::RES_FINE;
        end else if (k_res && i_res_target_right) begin
            res_r_ff <= res_next(res_r_ff); // see RULE10 see RULE11
        end else if (k_res) begin
            res_l_ff <= res_next(res_l_ff); // see RULE10
        end
    end

    // ****************************************************************
    // Function menu
    // ****************************************************************
    // Open, scroll, apply or drop; item survives closing
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            menu_ff <= front_panel_pkg::MENU_IDLE;
            item_ff <= front_panel_pkg::ITEM_RST;
            pend_ff <= '0;
            apply_ff <= 1'b0;
            dflt_ff <= 1'b0;
        end else begin
            apply_ff <= 1'b0;
            dflt_ff <= 1'b0;
            case (menu_ff)
                front_panel_pkg::MENU_IDLE: begin
                    if (k_fn) begin
                        menu_ff <= front_panel_pkg::MENU_OPEN; // see RULE9
                        pend_ff <= '0;
                    end
                end
                front_panel_pkg::MENU_OPEN: begin
                    if (k_clear) begin
                        menu_ff <= front_panel_pkg::MENU_IDLE; // see RULE13
                        dflt_ff <= 1'b1;
                    end else if (k_ent) begin
                        menu_ff <= front_panel_pkg::MENU_IDLE; // see RULE5
                        apply_ff <= 1'b1;
                        dflt_ff <= 1'b1;
                    end else if (k_enc || k_other) begin
                        menu_ff <= front_panel_pkg::MENU_IDLE; // see RULE6 see RULE22
                    end else if (k_fn) begin
                        item_ff <= 4'(item_ff + 4'h1); // Next item
                        pend_ff <= '0;
                    end else if (k_up) begin
                        pend_ff <= i_key_up ? 8'(pend_ff + 8'h01) : 8'(pend_ff - 8'h01);
                        apply_ff <= !item_blink; // see RULE8
                    end
                end
                default: begin
                    menu_ff <= front_panel_pkg::MENU_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Indicators
    // ****************************************************************
    // Blink divider
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            blink_cnt_ff <= '0;
            blink_ff <= 1'b0;
        end else if (blink_cnt_ff == front_panel_pkg::CNT_W'(BLINK_CYC - 1)) begin
            blink_cnt_ff <= '0;
            blink_ff <= !blink_ff;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 1'b1;
        end
    end
    wire busy = ctrl_ff[front_panel_pkg::C_SELFTEST] || ctrl_ff[front_panel_pkg::C_SEQ];
    wire ready = ctrl_ff[front_panel_pkg::C_READY];
    assign o_ready_led = ready && (busy ? blink_ff : 1'b1); // see RULE20
    assign o_addr_led = i_bus_addressed; // see RULE21
    assign o_srq_led = i_bus_srq; // see RULE21
    assign o_remote_led = i_remote;
    assign o_panel_locked_indicator = panel_locked;
    assign o_output_on = out_ff;
    assign o_overtemp_trip = otp_ff;
    assign o_overcurrent_trip = oc_ff;
    assign o_go_local = golocal_ff;
    assign o_config_reset = cfg_rst_ff;
    assign o_menu_open = menu_open;
    assign o_menu_item = item_ff;
    assign o_menu_param = pend_ff;
    assign o_param_blink = menu_open && item_text && item_blink; // see RULE22
    assign o_param_apply = apply_ff;
    assign o_display_default = dflt_ff;
    assign o_res_left = res_l_ff;
    assign o_res_right = res_r_ff;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_otp_off;
        @(posedge i_core_clk) disable iff (i_reset) i_overtemp |=> !o_output_on;
    endproperty
    a_otp_off: assert property (p_otp_off) else $error("output on after overtemp"); // see RULE1
    property p_oc_trip;
        @(posedge i_core_clk) disable iff (i_reset)
            (cc_over && out_ff && !i_overtemp) |=> (oc_ff && !out_ff);
    endproperty
    a_oc_trip: assert property (p_oc_trip) else $error("no overcurrent trip"); // see RULE2
    property p_oc_hold;
        @(posedge i_core_clk) disable iff (i_reset)
            (oc_ff && !i_cmd_output_on && !k_out) |=> !out_ff;
    endproperty
    a_oc_hold: assert property (p_oc_hold) else $error("output on after trip"); // see RULE3
    // The lamp may only come on from the key combination or the trigger lock
    property p_lamp_llo;
        @(posedge i_core_clk) disable iff (i_reset)
            $rose(o_panel_locked_indicator) |-> ($past(combo_lock) || trig_lock);
    endproperty
    a_lamp_llo: assert property (p_lamp_llo) else $error("lock lamp wrong"); // see RULE4
    property p_enter;
        @(posedge i_core_clk) disable iff (i_reset)
            (menu_open && k_ent && !k_clear) |=>
                (o_param_apply && o_display_default && !o_menu_open);
    endproperty
    a_enter: assert property (p_enter) else $error("enter did not apply"); // see RULE5
    property p_abandon;
        @(posedge i_core_clk) disable iff (i_reset)
            (menu_open && k_enc && !k_ent && !k_clear) |=> (!o_menu_open && !o_param_apply);
    endproperty
    a_abandon: assert property (p_abandon) else $error("menu not abandoned"); // see RULE6
    property p_res_fine;
        @(posedge i_core_clk) disable iff (i_reset)
            cfg_rst_ff |=> (res_l_ff == front_panel_pkg::RES_FINE &&
                            res_r_ff == front_panel_pkg::RES_FINE);
    endproperty
    a_res_fine: assert property (p_res_fine) else $error("resolution not fine"); // see RULE12
    property p_llo_clear;
        @(posedge i_core_clk) disable iff (i_reset) i_bus_llo |=> !o_go_local;
    endproperty
    a_llo_clear: assert property (p_llo_clear) else $error("clear under lockout"); // see RULE15
    property p_lock;
        @(posedge i_core_clk) disable iff (i_reset) combo_lock |=> o_panel_locked_indicator;
    endproperty
    a_lock: assert property (p_lock) else $error("panel not locked"); // see RULE17
    property p_ready;
        @(posedge i_core_clk) disable iff (i_reset) !ready |-> !o_ready_led;
    endproperty
    a_ready: assert property (p_ready) else $error("ready lamp lit"); // see RULE20
endmodule
`default_nettype wire

/* File: sim/front_panel_operator.sv */
// Operator model pressing panel keys and holding the clear key
`timescale 1ns/1ps
`default_nettype none
module front_panel_operator (
    input wire logic i_core_clk,
    output logic [11:0] o_keys,
    output logic o_clear_held
);
    // Hands off the panel at time zero
    initial begin
        o_keys = 12'h000;
        o_clear_held = 1'b0;
    end
    // One key pulse, one clock wide
    task automatic press(input int k);
        @(posedge i_core_clk);
        o_keys <= 12'h001 << k;
        @(posedge i_core_clk);
        o_keys <= 12'h000;
    endtask
    // Clear key held for n edges without a break
    task automatic hold(input int n);
        @(posedge i_core_clk);
        o_clear_held <= 1'b1;
        repeat (n) @(posedge i_core_clk);
        o_clear_held <= 1'b0;
    endtask
    // Clear key held while a second key is pressed
    task automatic chord(input int k);
        @(posedge i_core_clk);
        o_clear_held <= 1'b1;
        press(k);
        @(posedge i_core_clk);
        o_clear_held <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: sim/front_panel_control_logic_tb.sv */
// Self-checking testbench of the front panel control logic
`timescale 1ns/1ps
`default_nettype none
module front_panel_control_logic_tb;
    // ****************************************
    // Signals
    // ****************************************
    localparam int OUT = 0, FUN = 1, UP = 2, ENT = 4, RECALL = 5, RES = 8, CLR = 9, ENC = 10;
    logic i_core_clk = 1'b0, i_reset = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic [7:0] i_wb_adr = 8'h00;
    logic [3:0] i_wb_sel = 4'hF;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
    logic [11:0] keys;
    logic i_key_output, i_key_function, i_key_up, i_key_down, i_key_enter, i_key_recall;
    logic i_key_save, i_key_select, i_step_resolution_key, i_key_clear_held, i_key_clear_press;
    logic i_enc_left, i_enc_right, i_res_target_right = 1'b0, i_overtemp = 1'b0, i_cur_reg = 1'b0;
    logic i_trigger_in = 1'b0, i_remote = 1'b0, i_bus_llo = 1'b0, i_bus_addressed = 1'b0;
    logic i_bus_srq = 1'b0, i_cmd_output_on = 1'b0, i_cmd_output_off = 1'b0, i_delay_tick = 1'b0;
    logic o_wb_ack, o_output_on, o_overtemp_trip, o_overcurrent_trip, o_panel_locked_indicator;
    logic o_ready_led, o_remote_led, o_addr_led, o_srq_led, o_go_local, o_config_reset;
    logic o_menu_open, o_param_blink, o_param_apply, o_display_default;
    logic [3:0] o_menu_item;
    logic [7:0] o_menu_param;
    logic [1:0] o_res_left, o_res_right;
    int error_cnt = 0, checks = 0, cyc_cnt = 0;
    assign {i_enc_right, i_enc_left, i_key_clear_press, i_step_resolution_key, i_key_select,
        i_key_save, i_key_recall, i_key_enter, i_key_down, i_key_up, i_key_function,
        i_key_output} = keys;
    // Short hold and blink counts keep the run brief
    front_panel_control_logic #(.UNLOCK_CYC(16), .BLINK_CYC(4)) u_front_panel_control_logic (.*);
    front_panel_operator u_front_panel_operator (.i_core_clk(i_core_clk), .o_keys(keys),
        .o_clear_held(i_key_clear_held));
    always #4 i_core_clk = ~i_core_clk;
    // Hang guard, far above the length of all tests
    always @(posedge i_core_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            complete_run();
        end
    end
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // Classic cycle, held until ack is seen at an edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge i_core_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= adr;
        i_wb_dat <= dat;
        @(posedge i_core_clk);
        while (o_wb_ack !== 1'b1) @(posedge i_core_clk);
        rd = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask
    // Key press, then let the answering edge land
    task automatic key(input int k);
        u_front_panel_operator.press(k);
        #1;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    task automatic t_res;
        chk(o_res_left, 32'h0);
        chk(o_ready_led, 32'h1);
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        for (int i = 1; i < 5; i++) begin
            key(RES);
            chk(o_res_left, i % 3);
        end
        @(posedge i_core_clk);
        i_res_target_right <= 1'b1;
        key(RES);
        chk({o_res_left, o_res_right}, 32'h5);
        $display("test resolution done");
    endtask
    // Trip needs more ticks than the delay; a bus output-on command revives it
    task automatic t_prot;
        wb(1'b1, 8'h00, 32'h21);
        wb(1'b1, 8'h08, 32'h2);
        key(OUT);
        @(posedge i_core_clk);
        i_cur_reg <= 1'b1;
        i_delay_tick <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        #1 chk(o_overcurrent_trip, 32'h0);
        repeat (3) @(posedge i_core_clk);
        #1 chk({o_overcurrent_trip, o_output_on}, 32'h2);
        @(posedge i_core_clk);
        i_cur_reg <= 1'b0;
        i_delay_tick <= 1'b0;
        i_cmd_output_on <= 1'b1;
        @(posedge i_core_clk);
        i_cmd_output_on <= 1'b0;
        #1 chk(o_output_on, 32'h1);
        wb(1'b1, 8'h00, 32'h23);
        i_overtemp <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        #1 chk({o_overtemp_trip, o_output_on}, 32'h2);
        @(posedge i_core_clk);
        i_overtemp <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1 chk(o_output_on, 32'h1);
        $display("test protection done");
    endtask
    task automatic t_menu;
        key(FUN);
        key(UP);
        chk({o_param_apply, o_menu_param}, 32'h101);
        key(ENT);
        chk({o_menu_open, o_display_default}, 32'h1);
        key(FUN);
        key(FUN);
        key(ENC);
        chk({o_menu_open, o_param_apply}, 32'h0);
        key(FUN);
        chk(o_menu_item, 32'h1);
        key(CLR);
        chk({o_menu_open, o_display_default, o_param_apply}, 32'h2);
        $display("test menu done");
    endtask
    // Locked panel, unlock only after a long unbroken hold
    task automatic t_lock;
        u_front_panel_operator.chord(RECALL);
        #1 chk(o_panel_locked_indicator, 32'h1);
        key(OUT);
        chk(o_output_on, 32'h1);
        u_front_panel_operator.hold(8);
        #1 chk(o_panel_locked_indicator, 32'h1);
        u_front_panel_operator.hold(20);
        #1 chk(o_panel_locked_indicator, 32'h0);
        @(posedge i_core_clk);
        i_remote <= 1'b1;
        i_bus_llo <= 1'b1;
        key(CLR);
        chk({o_go_local, o_remote_led}, 32'h1);
        @(posedge i_core_clk);
        i_bus_llo <= 1'b0;
        key(CLR);
        chk(o_go_local, 32'h1);
        @(posedge i_core_clk);
        i_remote <= 1'b0;
        u_front_panel_operator.chord(ENT);
        #1 chk(o_res_right, 32'h0);
        wb(1'b1, 8'h00, 32'h24);
        i_trigger_in <= 1'b1;
        i_bus_addressed <= 1'b1;
        i_bus_srq <= 1'b1;
        #1 chk({o_panel_locked_indicator, o_addr_led, o_srq_led}, 32'h7);
        $display("test lock and remote done");
    endtask
    initial begin
        repeat (12) @(posedge i_core_clk);
        i_reset <= 1'b0;
        #1;
        t_res();
        t_prot();
        t_menu();
        t_lock();
        complete_run();
    end
endmodule
`default_nettype wire
